// *** core/adc_col_top.v ***
// Contract
// - Sample one word on each selected strobe edge, at any rate.
// - Capture strobe is any of four lines, rising or falling edge.
// - Lines 0 and 1 come from card or pattern generator by config.
// - Only coupling to the pattern generator is the four strobe lines.
// - Generator strobes capture without a device; device strobes need it running.
// - Modes: parallel, serial, byte bus, I2S; bytes taken on strobe edge.
// - Serial capture uses clock, data and frame sync wires.
// - Serial clock from strobe lines or data bits 0, 1, 14, 15.
// - One bit shifted per selected serial clock edge, rising or falling.
// - Serial data from strobe lines or data bits 2, 3, 12, 13.
// - Frame sync from strobe lines; its edge loads the output latch.
// - Word length any value 6 through 16 bits.
// - First bit is msb or lsb by configuration.
// - Shift register is static, no minimum serial clock rate.
// - I2S: falling edge takes left words, rising edge right words; code takes only the set strobe edge.
// - Words read as straight binary or two's complement by config.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_col_regs.vh"
module adc_col_top (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire [15:0] dut_data_i,
	input  wire        strobe_line_0_card_i,
	input  wire        strobe_line_1_card_i,
	input  wire [3:0]  strobe_pg_i,
	output reg  [15:0] word_o,
	output reg         word_vld_o,
	output reg         word_left_o,
	output reg         no_dut_o
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [8:0]  ctrl;
	reg  [16:0] ser;
	reg  [31:0] timeout;
	reg  [31:0] idle_cnt;
	reg  [31:0] word_cnt;
	reg         clr_pend;
	reg         ack;

	wire [1:0] mode      = ctrl[`ADC_CTRL_MODE_HI:`ADC_CTRL_MODE_LO];
	wire [1:0] stb_sel   = ctrl[`ADC_CTRL_STB_HI:`ADC_CTRL_STB_LO];
	wire       stb_fall  = ctrl[`ADC_CTRL_STB_FALL];
	wire       twos      = ctrl[`ADC_CTRL_TWOS];
	wire       enable    = ctrl[`ADC_CTRL_ENABLE];
	wire [2:0] sclk_sel  = ser[`ADC_SER_CLK_HI:`ADC_SER_CLK_LO];
	wire [2:0] sdat_sel  = ser[`ADC_SER_DAT_HI:`ADC_SER_DAT_LO];
	wire [1:0] fs_sel    = ser[`ADC_SER_FS_HI:`ADC_SER_FS_LO];
	wire       sclk_fall = ser[`ADC_SER_CLK_FALL];
	wire       fs_fall   = ser[`ADC_SER_FS_FALL];
	wire       lsb_first = ser[`ADC_SER_LSB_FIRST];
	wire [4:0] len_raw   = ser[`ADC_SER_LEN_HI:`ADC_SER_LEN_LO];
	// Out-of-range lengths are clamped rather than refused
	wire [4:0] len = (len_raw < `ADC_LEN_MIN) ? `ADC_LEN_MIN :
		(len_raw > `ADC_LEN_MAX) ? `ADC_LEN_MAX : len_raw;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the generator only reaches us via these lines
	wire [3:0]  stb_raw;
	reg  [3:0]  stb_m;
	reg  [3:0]  stb_s;
	reg  [3:0]  stb_d;
	reg  [15:0] dat_m;
	reg  [15:0] dat_s;
	reg  [15:0] dat_d;

	assign stb_raw[0] = ctrl[`ADC_CTRL_PG0] ? strobe_pg_i[0] : strobe_line_0_card_i;
	assign stb_raw[1] = ctrl[`ADC_CTRL_PG1] ? strobe_pg_i[1] : strobe_line_1_card_i;
	assign stb_raw[3:2] = strobe_pg_i[3:2];

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stb_m <= 4'h0;
			stb_s <= 4'h0;
			stb_d <= 4'h0;
			dat_m <= 16'h0000;
			dat_s <= 16'h0000;
			dat_d <= 16'h0000;
		end else begin
			stb_m <= stb_raw;
			stb_s <= stb_m;
			stb_d <= stb_s;
			dat_m <= dut_data_i;
			dat_s <= dat_m;
			dat_d <= dat_s;
		end
	end

	// Pick a rising or falling edge on a synchronised line
	function edge_of;
		input now;
		input was;
		input fall;
		begin
			edge_of = fall ? (was & ~now) : (now & ~was);
		end
	endfunction

	// Eight-way source pick: strobe lines, then four data bits
	function pick8;
		input [2:0] sel;
		input [3:0] stb;
		input [3:0] dbits;
		begin
			pick8 = sel[2] ? dbits[sel[1:0]] : stb[sel[1:0]];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Edge detection
	wire cap_edge = edge_of(stb_s[stb_sel], stb_d[stb_sel], stb_fall);
	wire [3:0] ck_now = {dat_s[15], dat_s[14], dat_s[1], dat_s[0]};
	wire [3:0] ck_was = {dat_d[15], dat_d[14], dat_d[1], dat_d[0]};
	wire [3:0] dt_now = {dat_s[13], dat_s[12], dat_s[3], dat_s[2]};
	wire sclk_now = pick8(sclk_sel, stb_s, ck_now);
	wire sclk_was = pick8(sclk_sel, stb_d, ck_was);
	// Data read from the delayed stage so it is the value before the edge
	wire sdat_bit = pick8(sdat_sel, stb_d, {dat_d[13], dat_d[12], dat_d[3], dat_d[2]});
	wire ser_mode = (mode == `ADC_MODE_SER);
	wire shift_ev = enable & ser_mode & edge_of(sclk_now, sclk_was, sclk_fall);
	// Frame sync sampled with the clock; the far end keeps it off shift edges
	wire frame_ev = enable & ser_mode & edge_of(stb_s[fs_sel], stb_d[fs_sel], fs_fall);
	wire [3:0] unused_dt = dt_now;

	wire [15:0] ser_word;
	wire        ser_vld;

	adc_col_deser u_deser (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.shift_i     (shift_ev),
		.bit_i       (sdat_bit),
		.frame_i     (frame_ev),
		.len_i       (len),
		.lsb_first_i (lsb_first),
		.word_o      (ser_word),
		.word_vld_o  (ser_vld)
	);

	////////////////////////////////////////////////////////////////////////
	// Word assembly
	wire par_ev = enable & (mode != `ADC_MODE_SER) & cap_edge;
	reg  [15:0] raw_word;
	reg         raw_vld;

	// Low bits below the word length read zero, as do unconnected pins
	function [15:0] len_mask;
		input [4:0] n;
		begin
			len_mask = ~(16'hffff >> n);
		end
	endfunction

	always @* begin
		raw_word = 16'h0000;
		raw_vld  = 1'b0;
		if (ser_vld) begin
			raw_word = ser_word;
			raw_vld  = 1'b1;
		end else if (par_ev) begin
			raw_vld = 1'b1;
			if (mode == `ADC_MODE_BYTE)
				raw_word = {dat_d[15:8], 8'h00};
			else
				raw_word = dat_d & len_mask(len);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stream and timeout watch
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_o      <= 16'h0000;
			word_vld_o  <= 1'b0;
			word_left_o <= 1'b0;
			word_cnt    <= 32'h00000000;
			idle_cnt    <= 32'h00000000;
			no_dut_o    <= 1'b0;
		end else begin
			word_vld_o <= raw_vld;
			if (raw_vld) begin
				// Straight binary is shown as two's complement by flipping msb
				word_o      <= twos ? raw_word : (raw_word ^ 16'h8000);
				word_left_o <= (mode == `ADC_MODE_I2S) & stb_fall;
				word_cnt    <= word_cnt + 32'h00000001;
			end
			// Counter parks at the limit; a shortened limit still trips at once
			if (raw_vld | shift_ev | ~enable)
				idle_cnt <= 32'h00000000;
			else if (idle_cnt < timeout)
				idle_cnt <= idle_cnt + 32'h00000001;
			// Set wins over a simultaneous status register clear; a word in the same cycle clears instead
			if (enable & ~raw_vld & (idle_cnt >= timeout))
				no_dut_o <= 1'b1;
			else if (clr_pend | raw_vld)
				no_dut_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, answer on the second edge
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl            <= `ADC_CTRL_RST;
			ser             <= `ADC_SER_RST;
			timeout         <= `ADC_TIMEOUT_RST;
			clr_pend        <= 1'b0;
			ack             <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			clr_pend        <= 1'b0;
			ack             <= (avs_read | avs_write) & ~ack;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack);
			if ((avs_read | avs_write) & ~ack) begin
				avs_readdata <= 32'h00000000;
				if (avs_write) begin
					case (avs_address)
					`ADC_REG_CTRL:    ctrl    <= avs_writedata[8:0];
					`ADC_REG_SER:     ser     <= avs_writedata[16:0];
					`ADC_REG_TIMEOUT: timeout <= avs_writedata;
					`ADC_REG_STATUS:  clr_pend <= avs_writedata[0];
					default:          ;
					endcase
				end else begin
					case (avs_address)
					`ADC_REG_CTRL:    avs_readdata <= {23'h000000, ctrl};
					`ADC_REG_SER:     avs_readdata <= {15'h0000, ser};
					`ADC_REG_TIMEOUT: avs_readdata <= timeout;
					`ADC_REG_STATUS:  avs_readdata <= {28'h0000000, unused_dt[0] & 1'b0,
						word_left_o, enable, no_dut_o};
					`ADC_REG_DATA:    avs_readdata <= {16'h0000, word_o};
					`ADC_REG_COUNT:   avs_readdata <= word_cnt;
					default:          avs_readdata <= 32'h00000000;
					endcase
				end
			end
		end
	end
endmodule // adc_col_top
`default_nettype wire

// *** core/adc_col_regs.vh ***
`ifndef ADC_COL_REGS_VH
`define ADC_COL_REGS_VH
// Register word offsets (byte address = 4 * index)
`define ADC_REG_CTRL     4'h0
`define ADC_REG_SER      4'h1
`define ADC_REG_TIMEOUT  4'h2
`define ADC_REG_STATUS   4'h3
`define ADC_REG_DATA     4'h4
`define ADC_REG_COUNT    4'h5
// Control fields
`define ADC_CTRL_MODE_LO   0
`define ADC_CTRL_MODE_HI   1
`define ADC_CTRL_STB_LO    2
`define ADC_CTRL_STB_HI    3
`define ADC_CTRL_STB_FALL  4
`define ADC_CTRL_PG0       5
`define ADC_CTRL_PG1       6
`define ADC_CTRL_TWOS      7
`define ADC_CTRL_ENABLE    8
// Serial fields
`define ADC_SER_CLK_LO     0
`define ADC_SER_CLK_HI     2
`define ADC_SER_DAT_LO     3
`define ADC_SER_DAT_HI     5
`define ADC_SER_FS_LO      6
`define ADC_SER_FS_HI      7
`define ADC_SER_CLK_FALL   8
`define ADC_SER_FS_FALL    9
`define ADC_SER_LSB_FIRST  10
`define ADC_SER_LEN_LO     12
`define ADC_SER_LEN_HI     16
// Modes
`define ADC_MODE_PAR     2'h0
`define ADC_MODE_SER     2'h1
`define ADC_MODE_BYTE    2'h2
`define ADC_MODE_I2S     2'h3
// Reset values and word length limits
`define ADC_CTRL_RST     9'h000
`define ADC_SER_RST      17'h10000
`define ADC_TIMEOUT_RST  32'h00989680
`define ADC_LEN_MIN      5'h06
`define ADC_LEN_MAX      5'h10
`endif

// *** core/adc_col_deser.v ***
`timescale 1ns/1ps
`default_nettype none
// Serial shifter; runs off edge pulses from the sampled serial clock and sync
module adc_col_deser (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire        shift_i,
	input  wire        bit_i,
	input  wire        frame_i,
	input  wire [4:0]  len_i,
	input  wire        lsb_first_i,
	output reg  [15:0] word_o,
	output reg         word_vld_o
);
	reg [15:0] shreg;
	integer    k;
	reg [15:0] aligned;

	// Static register: holds forever between shift edges, no minimum rate
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shreg <= 16'h0000;
		end else if (shift_i) begin
			if (lsb_first_i) begin
				shreg <= {bit_i, shreg[15:1]};
			end else begin
				shreg <= {shreg[14:0], bit_i};
			end
		end
	end

	// Align the last len bits so the first bit lands on bit 15 when msb first
	always @* begin
		aligned = 16'h0000;
		for (k = 0; k < 16; k = k + 1) begin
			if (lsb_first_i) begin
				if (k < len_i)
					aligned[15 - k] = shreg[15 - k];
			end else begin
				if (k < len_i)
					aligned[15 - k] = shreg[len_i - 1 - k];
			end
		end
	end

	// Second stage latch on the chosen frame sync edge
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_o     <= 16'h0000;
			word_vld_o <= 1'b0;
		end else begin
			word_vld_o <= frame_i;
			if (frame_i)
				word_o <= aligned;
		end
	end
endmodule // adc_col_deser
`default_nettype wire

// *** tb/adc_col_conv.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_col_conv #(
	parameter int BITS = 12
) (
	output var logic [15:0] dut_data_o,
	output var logic        strobe_line_0_card_o,
	output var logic        strobe_line_1_card_o
);
	initial begin
		dut_data_o = 16'h0000;
		strobe_line_0_card_o = 1'b0;
		strobe_line_1_card_o = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// Narrow word sits at the top; unused low pins are pulled low
	task automatic put(input logic [15:0] w);
		dut_data_o = w & ~((16'h0001 << (16 - BITS)) - 16'h0001);
	endtask
	task automatic pulse(input logic ln);
		#40;
		if (ln) strobe_line_1_card_o = 1'b1;
		else strobe_line_0_card_o = 1'b1;
		#60;
		{strobe_line_1_card_o, strobe_line_0_card_o} = 2'b00;
		#40;
	endtask
	// Clock on bit 0, data on bit 2, sync on card line 0; clock idles between frames
	task automatic frame(input logic [15:0] w, input int len, input logic lsb, input int gap);
		for (int i = 0; i < len; i++) begin
			dut_data_o[2] = lsb ? w[i] : w[len - 1 - i];
			#(24 + gap) dut_data_o[0] = 1'b1;
			#24 dut_data_o[0] = 1'b0;
		end
		#12 dut_data_o[2] = ~dut_data_o[2];
		// Sync moves half a clock after the last bit, clear of every shift edge
		#12 strobe_line_0_card_o = 1'b1;
		#48 strobe_line_0_card_o = 1'b0;
		#48;
	endtask
endmodule // adc_col_conv
`default_nettype wire

// *** tb/adc_col_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_col_chk (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [15:0] dut_data_i,
	input wire logic        strobe_line_0_card_i,
	input wire logic        strobe_line_1_card_i,
	input wire logic [3:0]  strobe_pg_i,
	input wire logic [15:0] word_o,
	input wire logic        word_vld_o,
	input wire logic        word_left_o,
	input wire logic        no_dut_o
);
	logic [8:0] ctrl;
	logic       sel_q;
	wire        take = avs_write && !avs_waitrequest;
	wire  [3:0] lines = {strobe_pg_i[3:2], ctrl[6] ? strobe_pg_i[1] : strobe_line_1_card_i,
		ctrl[5] ? strobe_pg_i[0] : strobe_line_0_card_i};
	wire        sel = lines[ctrl[3:2]];
	wire        par = ctrl[8] && ctrl[1:0] != 2'h1;
	// Shadow of the control word so checks follow the live setting
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl <= 9'h000;
			sel_q <= 1'b0;
		end else begin
			if (take && avs_address == 4'h0)
				ctrl <= avs_writedata[8:0];
			sel_q <= sel;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_pulse; word_vld_o |=> !word_vld_o; endproperty
	a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
	property p_capture; par && sel != sel_q && sel == !ctrl[4] |-> ##[1:8] word_vld_o; endproperty
	a_capture: assert property (p_capture) else $error("strobe edge gave no word");
	property p_coding; word_vld_o && par && ctrl[1:0] == 2'h0 |->
		word_o == {dut_data_i[15] ^ !ctrl[7], dut_data_i[14:0]}; endproperty
	a_coding: assert property (p_coding) else $error("word coding wrong");
	property p_left; word_vld_o && ctrl[1:0] == 2'h3 |-> word_left_o == ctrl[4]; endproperty
	a_left: assert property (p_left) else $error("channel flag wrong");
	property p_sticky; no_dut_o && !(take && avs_address == 4'h3 && avs_writedata[0]) |=>
		no_dut_o || word_vld_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("timeout flag dropped");
	property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
	property p_once; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_once: assert property (p_once) else $error("wait low too long");
	property p_unmapped; avs_read && !avs_waitrequest && avs_address > 4'h5 |-> avs_readdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_byte: cover property (word_vld_o && ctrl[1:0] == 2'h2);
	c_left: cover property (word_vld_o && word_left_o);
	c_nodut: cover property (no_dut_o);
endmodule // adc_col_chk
bind adc_col_top adc_col_chk adc_col_chk_i (.clk_i, .rstn_i, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .dut_data_i, .strobe_line_0_card_i,
	.strobe_line_1_card_i, .strobe_pg_i, .word_o, .word_vld_o, .word_left_o, .no_dut_o);
`default_nettype wire

// *** tb/adc_data_collector_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_data_collector_bench;
	typedef struct {logic [8:0] c; logic [15:0] d; logic [2:0] s; logic [15:0] e; int n;} adc_row_t;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	wire  [15:0] dut_data_i;
	wire         strobe_line_0_card_i;
	wire         strobe_line_1_card_i;
	logic [3:0]  strobe_pg_i = 4'h0;
	logic [15:0] word_o;
	logic        word_vld_o;
	logic        word_left_o;
	logic        no_dut_o;
	logic [15:0] got;
	logic [31:0] rd;
	int          n_vld = 0;
	int          c0;
	int          n_errors = 0;
	int          total_checks = 0;
	logic [31:0] rst_val [3] = '{32'h0, 32'h10000, 32'h989680};
	// Source 0-3 pulses a generator line, 4-5 a card line
	adc_row_t    rows [10] = '{
		'{9'h108, 16'h8000, 3'd2, 16'h0000, 1}, '{9'h19c, 16'h1234, 3'd3, 16'h1230, 1},
		'{9'h100, 16'h7ff0, 3'd4, 16'hfff0, 1}, '{9'h1a0, 16'habc0, 3'd0, 16'habc0, 1},
		'{9'h100, 16'h1111, 3'd0, 16'h0000, 0}, '{9'h1d4, 16'h0f00, 3'd1, 16'h0f00, 1},
		'{9'h18a, 16'h5a00, 3'd2, 16'h5a00, 1}, '{9'h19f, 16'h4444, 3'd3, 16'h4440, 1},
		'{9'h18f, 16'h2220, 3'd3, 16'h2220, 1}, '{9'h184, 16'h0013, 3'd5, 16'h0010, 1}};
	adc_col_top adc_col_top_i (.clk_i, .rstn_i, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .dut_data_i, .strobe_line_0_card_i,
		.strobe_line_1_card_i, .strobe_pg_i, .word_o, .word_vld_o, .word_left_o, .no_dut_o);
	adc_col_conv adc_col_conv_i (.dut_data_o(dut_data_i),
		.strobe_line_0_card_o(strobe_line_0_card_i), .strobe_line_1_card_o(strobe_line_1_card_i));
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (word_vld_o === 1'b1) begin
			got <= word_o;
			n_vld <= n_vld + 1;
		end
	end
	////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Held until waitrequest is seen low; one idle edge so no signal is set twice at once
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= ~wr;
		avs_write <= wr;
		do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_i);
	endtask
	task edge_on(input logic [2:0] s);
		if (s < 3'd4) begin
			strobe_pg_i[s[1:0]] <= 1'b1;
			repeat (12) @(posedge clk_i);
			strobe_pg_i[s[1:0]] <= 1'b0;
		end else begin
			adc_col_conv_i.pulse(s[0]);
			@(posedge clk_i);
		end
	endtask
	task ser(input logic [31:0] cfg, input logic [15:0] w, input int len, input logic lsb,
		input int gap, input logic [15:0] e);
		bus(1'b1, 4'h1, cfg, rd);
		c0 = n_vld;
		adc_col_conv_i.frame(w, len, lsb, gap);
		repeat (20) @(posedge clk_i);
		chk("serial count", 32'd1, 32'(n_vld - c0));
		chk("serial word", {16'h0, e}, {16'h0, got});
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		chk("reset wait", 32'h1, {31'h0, avs_waitrequest});
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 4'(i), 32'h0, rd);
			chk("reset reg", rst_val[i], rd);
		end
		bus(1'b1, 4'hf, 32'hffffffff, rd);
		bus(1'b0, 4'hf, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		foreach (rows[i]) begin
			adc_col_conv_i.put(rows[i].d);
			bus(1'b1, 4'h0, {23'h0, rows[i].c}, rd);
			repeat (10) @(posedge clk_i);
			c0 = n_vld;
			edge_on(rows[i].s);
			repeat (20) @(posedge clk_i);
			chk("count", 32'(rows[i].n), 32'(n_vld - c0));
			if (rows[i].n > 0) chk("word", {16'h0, rows[i].e}, {16'h0, got});
		end
		bus(1'b1, 4'h0, 32'h181, rd);
		ser(32'h6424, 16'h002d, 6, 1'b1, 0, 16'hb400);
		ser(32'h10024, 16'hc3a5, 16, 1'b0, 200, 16'hc3a5);
		bus(1'b0, 4'h5, 32'h0, rd);
		chk("word count", 32'(n_vld), rd);
		bus(1'b1, 4'h2, 32'd50, rd);
		repeat (80) @(posedge clk_i);
		chk("no dut", 32'h1, {31'h0, no_dut_o});
		bus(1'b0, 4'h3, 32'h0, rd);
		chk("status", 32'h1, {31'h0, rd[0]});
		bus(1'b1, 4'h2, 32'h989680, rd);
		bus(1'b1, 4'h3, 32'h1, rd);
		chk("no dut clear", 32'h0, {31'h0, no_dut_o});
		conclude();
	end
	initial begin
		#300000;
		n_errors++;
		conclude();
	end
endmodule // adc_data_collector_bench
`default_nettype wire
